/* src/xpt_pkg.sv */
// Constants shared by the crosspoint loader ends.
//Behaviour
// RULE_01 - Bits shift serially in on shift clock.
// RULE_02 - Transfer strobe copies all bits to latches.
// RULE_03 - Shift clock never slower than minimum rate.
// RULE_04 - Shift clock never faster than maximum rate.
// RULE_05 - Latches hold contents until next transfer.
// RULE_06 - Chain output is the final shift stage.
// RULE_07 - Devices chain output to next input.
// RULE_08 - Each latched bit drives one crosspoint.
// RULE_09 - Data sampled on rising shift clock edge.
// RULE_10 - First bit is row 15 column 15.
// RULE_11 - Strobe active low; latches follow while low.
// RULE_12 - Strobe within 5 ms after last shift.
// RULE_13 - Shifting never alters switch states.
package xpt_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int ROWS       = 32'h0000_0010;
    localparam int COLS       = 32'h0000_0010;
    localparam int SHIFT_BITS = ROWS * COLS;

    // ****************************************************************
    // Timing, as printed, and derived cycle counts at clk
    // ****************************************************************
    localparam int CLK_HZ        = 32'h0131_2D00;  // 20 MHz.
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int SCLK_MIN_HZ   = 32'h0000_4E20;  // 20 kHz.
    localparam int SCLK_MAX_HZ   = 32'h004C_4B40;  // 5 MHz.
    localparam int SCLK_PW_NS    = 32'h0000_0064;  // 100 ns high or low.
    localparam int XFER_DLY_NS   = 32'h0000_0041;  // 65 ns shift to strobe.
    localparam int XFER_PW_NS    = 32'h0000_0041;  // 65 ns strobe width.
    localparam int RETAIN_MS     = 32'h0000_0005;  // 5 ms data lifetime.

    // Least times round up, longest times round down.
    localparam int SCLK_HALF_MIN_CYC = (SCLK_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XFER_DLY_CYC      = (XFER_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XFER_PW_CYC       = (XFER_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_MIN_PER_CYC  = (CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
    localparam int SCLK_MAX_PER_CYC  = CLK_HZ / SCLK_MIN_HZ;
    localparam int RETAIN_CYC        = (CLK_HZ / 1000) * RETAIN_MS;

    // ****************************************************************
    // Controller states, Gray coded along the load path
    // ****************************************************************
    typedef enum logic [2:0] {
        XPT_IDLE   = 3'h0,
        XPT_LOW    = 3'h1,
        XPT_HIGH   = 3'h3,
        XPT_GAP    = 3'h2,
        XPT_STROBE = 3'h6
    } xpt_state_e;

endpackage

/* src/xpt_link_if.sv */
// Serial link between the crosspoint controller and the switch device.
`timescale 1ns/1ps
interface xpt_link_if;
    logic sclk;            // Shift clock, made by the controller.
    logic serial_data_in;  // Serial control bit into the device.
    logic xfer_n;          // Transfer strobe, active low.
    logic chain_data_out;  // Final shift stage of the device.

    modport ctrl (
        output sclk,
        output serial_data_in,
        output xfer_n,
        input  chain_data_out
    );

    modport dev (
        input  sclk,
        input  serial_data_in,
        input  xfer_n,
        output chain_data_out
    );
endinterface

/* src/xpt_device.sv */
// Crosspoint switch device: serial shift register, transfer latches, link monitor.
`timescale 1ns/1ps
module xpt_device #(
    parameter int ROWS       = xpt_pkg::ROWS,
    parameter int COLS       = xpt_pkg::COLS,
    parameter int RETAIN_CYC = xpt_pkg::RETAIN_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    xpt_link_if.dev                         link,
    output logic      [ROWS-1:0][COLS-1:0]  xpt_on_q,
    output logic                            update_q,
    output logic                            data_lost_q,
    output logic                            rate_slow_q,
    output logic                            rate_fast_q
);

    localparam int BITS   = ROWS * COLS;
    localparam int AGE_W  = $clog2(RETAIN_CYC + 1);
    localparam int CNT_W  = $clog2(BITS);
    localparam logic [AGE_W-1:0] AGE_MAX  = AGE_W'(RETAIN_CYC);
    localparam logic [AGE_W-1:0] AGE_SLOW = AGE_W'(xpt_pkg::SCLK_MAX_PER_CYC);
    localparam logic [AGE_W-1:0] AGE_FAST = AGE_W'(xpt_pkg::SCLK_MIN_PER_CYC - 1);

    // Refuse shapes the monitor cannot serve; the load counter wraps once per
    // full load, which only works for a power of two of bits.
    if (ROWS < 1 || COLS < 1 || BITS < 2 || (BITS & (BITS - 1)) != 0)
    begin : g_bad_shape
        $error("xpt_device: array must hold a power of two of bits");
    end
    if (RETAIN_CYC <= xpt_pkg::SCLK_MAX_PER_CYC)
    begin : g_bad_retain
        $error("xpt_device: retention shorter than slowest clock period");
    end

    // ****************************************************************
    // Link domain: the dynamic shift register
    // ****************************************************************
    logic [BITS-1:0] sr_q;
    logic [BITS-1:0] sr_d;

    // New bit enters stage 0, so the first bit reaches the top stage last.
    always_comb
    begin
        sr_d = {sr_q[BITS-2:0], link.serial_data_in};  // RULE_01 RULE_10
    end

    // No reset here: the stages hold nothing until a load fills them.
    always_ff @(posedge link.sclk)
    begin
        sr_q <= sr_d;  // RULE_09
    end

    // Top stage leaves straight for the next device in a chain.
    assign link.chain_data_out = sr_q[BITS-1];  // RULE_06 RULE_07

    // ****************************************************************
    // Local domain: synchronisers for strobe and shift clock
    // ****************************************************************
    logic xfer_s1_q;
    logic xfer_s2_q;
    logic xfer_s3_q;
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic xfer_s1_d;
    logic xfer_s2_d;
    logic xfer_s3_d;
    logic sclk_s1_d;
    logic sclk_s2_d;
    logic sclk_s3_d;

    // The third stage only serves edge detection on the settled second.
    // The first stage has no reset, so nothing but that flop sees the pin.
    always_comb
    begin
        xfer_s1_d = link.xfer_n;
        xfer_s2_d = xfer_s1_q;
        xfer_s3_d = xfer_s2_q;
        sclk_s1_d = link.sclk;
        sclk_s2_d = sclk_s1_q;
        sclk_s3_d = sclk_s2_q;
        if (!rstn)
        begin
            xfer_s2_d = 1'b1;
            xfer_s3_d = 1'b1;
            sclk_s2_d = 1'b0;
            sclk_s3_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        xfer_s1_q <= xfer_s1_d;
        xfer_s2_q <= xfer_s2_d;
        xfer_s3_q <= xfer_s3_d;
        sclk_s1_q <= sclk_s1_d;
        sclk_s2_q <= sclk_s2_d;
        sclk_s3_q <= sclk_s3_d;
    end

    logic shift_edge;
    logic xfer_fall;
    logic xfer_rise;
    logic xfer_low;

    // Events seen in the local domain.
    assign shift_edge = sclk_s2_q & ~sclk_s3_q;
    assign xfer_fall  = ~xfer_s2_q & xfer_s3_q;
    assign xfer_rise  = xfer_s2_q & ~xfer_s3_q;
    assign xfer_low   = ~xfer_s2_q;

    // ****************************************************************
    // Local domain: shift age, rate checks, transfer control
    // ****************************************************************
    logic [AGE_W-1:0] age_q;
    logic [AGE_W-1:0] age_d;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [CNT_W-1:0] bit_cnt_d;
    logic             xfer_ok_q;
    logic             xfer_ok_d;
    logic             update_d;
    logic             data_lost_d;
    logic             rate_slow_d;
    logic             rate_fast_d;
    logic             stale;
    logic             mid_load;

    assign stale    = (age_q == AGE_MAX);
    assign mid_load = (bit_cnt_q != '0);

    // A strobe that arrives after the data has aged out is refused, so
    // the switches keep their old pattern rather than take decayed bits.
    // Every flag set wins over the clear made by an accepted strobe.
    always_comb
    begin
        age_d       = stale ? age_q : age_q + AGE_W'(1);
        bit_cnt_d   = bit_cnt_q;
        xfer_ok_d   = xfer_ok_q;
        update_d    = 1'b0;
        data_lost_d = data_lost_q;
        rate_slow_d = rate_slow_q;
        rate_fast_d = rate_fast_q;
        if (xfer_fall)
        begin
            xfer_ok_d = ~stale;  // RULE_12
            if (!stale)
            begin
                data_lost_d = 1'b0;
                rate_slow_d = 1'b0;
                rate_fast_d = 1'b0;
                bit_cnt_d   = '0;
            end
            else
            begin
                data_lost_d = 1'b1;  // RULE_12
            end
        end
        if (xfer_rise)
        begin
            update_d  = xfer_ok_q;
            xfer_ok_d = 1'b0;
        end
        if (shift_edge)
        begin
            age_d     = '0;
            bit_cnt_d = bit_cnt_q + CNT_W'(1);
            if (age_q < AGE_FAST)
                rate_fast_d = 1'b1;  // RULE_04
        end
        else if (mid_load && age_q == AGE_SLOW)
        begin
            rate_slow_d = 1'b1;  // RULE_03
        end
        if (!rstn)
        begin
            age_d       = AGE_MAX;
            bit_cnt_d   = '0;
            xfer_ok_d   = 1'b0;
            update_d    = 1'b0;
            data_lost_d = 1'b0;
            rate_slow_d = 1'b0;
            rate_fast_d = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        age_q       <= age_d;
        bit_cnt_q   <= bit_cnt_d;
        xfer_ok_q   <= xfer_ok_d;
        update_q    <= update_d;
        data_lost_q <= data_lost_d;
        rate_slow_q <= rate_slow_d;
        rate_fast_q <= rate_fast_d;
    end

    // ****************************************************************
    // Static switch latches, one row per generate pass
    // ****************************************************************
    // The shift register is quiet while the strobe is low, since the
    // controller stops the shift clock, so the wide copy is stable.
    genvar r;
    generate
        for (r = 0; r < ROWS; r++)
        begin : g_row
            logic [COLS-1:0] row_d;

            always_comb
            begin
                row_d = xpt_on_q[r];  // RULE_05 RULE_13
                if (xfer_low && xfer_ok_q)
                    row_d = sr_q[r*COLS +: COLS];  // RULE_02 RULE_11 RULE_08
                if (!rstn)
                    row_d = '0;
            end

            always_ff @(posedge clk)
            begin
                xpt_on_q[r] <= row_d;
            end
        end
    endgenerate

endmodule

/* src/xpt_ctrl.sv */
// Crosspoint controller: makes the shift clock, shifts a pattern out, strobes it in.
`timescale 1ns/1ps
module xpt_ctrl #(
    parameter int N_DEV     = 1,
    parameter int HALF_CYC  = xpt_pkg::SCLK_HALF_MIN_CYC
) (
    input  wire logic                                clk,
    input  wire logic                                rstn,
    input  wire logic                                load_req,
    input  wire logic [N_DEV*xpt_pkg::SHIFT_BITS-1:0] load_data,
    output logic                                     busy_q,
    output logic                                     done_q,
    output logic                                     chain_ret_q,
    xpt_link_if.ctrl                                 link
);

    localparam int BITS  = N_DEV * xpt_pkg::SHIFT_BITS;
    localparam int CNT_W = $clog2(BITS + 1);
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF_CYC - 1);
    localparam logic [TMR_W-1:0] DLY_LAST  = TMR_W'(xpt_pkg::XFER_DLY_CYC - 1);
    localparam logic [TMR_W-1:0] PW_LAST   = TMR_W'(xpt_pkg::XFER_PW_CYC - 1);
    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BITS - 1);

    // A full period must lie between the fastest and slowest legal rate.
    if (N_DEV < 1)
    begin : g_bad_chain
        $error("xpt_ctrl: need at least one device");
    end
    if (2 * HALF_CYC < xpt_pkg::SCLK_MIN_PER_CYC || HALF_CYC < xpt_pkg::SCLK_HALF_MIN_CYC)
    begin : g_too_fast
        $error("xpt_ctrl: shift clock too fast");
    end
    if (2 * HALF_CYC > xpt_pkg::SCLK_MAX_PER_CYC || HALF_CYC > 255)
    begin : g_too_slow
        $error("xpt_ctrl: shift clock too slow");
    end

    xpt_pkg::xpt_state_e st_q;
    xpt_pkg::xpt_state_e st_d;
    logic [TMR_W-1:0]    tmr_q;
    logic [TMR_W-1:0]    tmr_d;
    logic [CNT_W-1:0]    bit_q;
    logic [CNT_W-1:0]    bit_d;
    logic [BITS-1:0]     shadow_q;
    logic [BITS-1:0]     shadow_d;
    logic                sclk_q;
    logic                sclk_d;
    logic                sdo_q;
    logic                sdo_d;
    logic                xfer_n_q;
    logic                xfer_n_d;
    logic                busy_d;
    logic                done_d;
    logic                ret_s1_q;
    logic                ret_d;

    // ****************************************************************
    // Load sequencer
    // ****************************************************************
    // Data changes with the falling shift clock, giving a full half period
    // of setup and of hold around each rising edge.
    always_comb
    begin
        st_d     = st_q;
        tmr_d    = tmr_q + TMR_W'(1);
        bit_d    = bit_q;
        shadow_d = shadow_q;
        sclk_d   = sclk_q;
        sdo_d    = sdo_q;
        xfer_n_d = xfer_n_q;
        busy_d   = busy_q;
        done_d   = 1'b0;
        case (st_q)
            xpt_pkg::XPT_IDLE:
            begin
                tmr_d = '0;
                if (load_req)
                begin
                    shadow_d = load_data;
                    sdo_d    = load_data[BITS-1];  // RULE_10
                    bit_d    = '0;
                    busy_d   = 1'b1;
                    st_d     = xpt_pkg::XPT_LOW;
                end
            end
            xpt_pkg::XPT_LOW:
            begin
                if (tmr_q == HALF_LAST)
                begin
                    tmr_d  = '0;
                    sclk_d = 1'b1;  // RULE_01 RULE_04
                    st_d   = xpt_pkg::XPT_HIGH;
                end
            end
            xpt_pkg::XPT_HIGH:
            begin
                if (tmr_q == HALF_LAST)
                begin
                    tmr_d  = '0;
                    sclk_d = 1'b0;  // RULE_03
                    bit_d  = bit_q + CNT_W'(1);
                    if (bit_q == BIT_LAST)
                        st_d = xpt_pkg::XPT_GAP;
                    else
                    begin
                        shadow_d = {shadow_q[BITS-2:0], 1'b0};
                        sdo_d    = shadow_q[BITS-2];  // RULE_07
                        st_d     = xpt_pkg::XPT_LOW;
                    end
                end
            end
            xpt_pkg::XPT_GAP:
            begin
                if (tmr_q == DLY_LAST)
                begin
                    tmr_d    = '0;
                    xfer_n_d = 1'b0;  // RULE_11 RULE_12
                    st_d     = xpt_pkg::XPT_STROBE;
                end
            end
            xpt_pkg::XPT_STROBE:
            begin
                if (tmr_q == PW_LAST)
                begin
                    xfer_n_d = 1'b1;  // RULE_11
                    busy_d   = 1'b0;
                    done_d   = 1'b1;
                    st_d     = xpt_pkg::XPT_IDLE;
                end
            end
            default:
            begin
                st_d = xpt_pkg::XPT_IDLE;
            end
        endcase
        ret_d = ret_s1_q;
        if (!rstn)
        begin
            st_d     = xpt_pkg::XPT_IDLE;
            tmr_d    = '0;
            bit_d    = '0;
            shadow_d = '0;
            sclk_d   = 1'b0;
            sdo_d    = 1'b0;
            xfer_n_d = 1'b1;
            busy_d   = 1'b0;
            done_d   = 1'b0;
            ret_d    = 1'b0;
        end
    end

    // The returning chain bit is a pin, so it passes two flops; the first
    // has no reset, so no logic stands between the pin and that flop.
    always_ff @(posedge clk)
    begin
        st_q        <= st_d;
        tmr_q       <= tmr_d;
        bit_q       <= bit_d;
        shadow_q    <= shadow_d;
        sclk_q      <= sclk_d;
        sdo_q       <= sdo_d;
        xfer_n_q    <= xfer_n_d;
        busy_q      <= busy_d;
        done_q      <= done_d;
        ret_s1_q    <= link.chain_data_out;
        chain_ret_q <= ret_d;
    end

    assign link.sclk           = sclk_q;
    assign link.serial_data_in = sdo_q;
    assign link.xfer_n         = xfer_n_q;

endmodule

/* verification/xpt_link_chk.sv */
// Concurrent checks on the serial link between controller and device.
`timescale 1ns/1ps
module xpt_link_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic xfer_n,
    input wire logic chain_data_out
);
    logic [255:0] hist_q;
    logic [255:0] hist_d;
    logic [8:0]   cnt_q;
    logic [8:0]   cnt_d;
    logic         sclk_q;
    logic         rise;

    // Shadow copy of the shift path; the count saturates so it never wraps.
    always_comb
    begin
        rise   = sclk & ~sclk_q;
        hist_d = rise ? {hist_q[254:0], serial_data_in} : hist_q;
        cnt_d  = (rise && cnt_q < 9'h100) ? cnt_q + 9'h001 : cnt_q;
    end

    // Registers of the shadow path.
    always_ff @(posedge clk)
    begin
        sclk_q <= rstn ? sclk : 1'b0;
        hist_q <= hist_d;
        cnt_q  <= rstn ? cnt_d : 9'h000;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_sclk_high; $rose(sclk) |=> sclk; endproperty
    property p_sclk_low; $fell(sclk) |=> !sclk; endproperty
    property p_data_hold;
        $rose(sclk) |-> $stable(serial_data_in) ##1 $stable(serial_data_in);
    endproperty
    property p_quiet_xfer; !xfer_n |-> !sclk; endproperty
    property p_xfer_width; $fell(xfer_n) |=> !xfer_n ##1 xfer_n; endproperty
    property p_xfer_delay;
        $fell(xfer_n) |-> $past(sclk, 3) && !$past(sclk, 2) && !$past(sclk);
    endproperty
    // The next device samples the chain output just before each rise.
    property p_chain_order;
        rise && cnt_q == 9'h100 |-> $past(chain_data_out) == hist_q[255];
    endproperty
    property p_chain_quiet; $changed(chain_data_out) |-> $rose(sclk); endproperty

    a_sclk_high: assert property (p_sclk_high)
        else $error("shift clock high phase too short");
    a_sclk_low: assert property (p_sclk_low)
        else $error("shift clock low phase too short");
    a_data_hold: assert property (p_data_hold)
        else $error("serial data moved around a shift clock rise");
    a_quiet_xfer: assert property (p_quiet_xfer)
        else $error("shift clock high during transfer strobe");
    a_xfer_width: assert property (p_xfer_width)
        else $error("transfer strobe width wrong");
    a_xfer_delay: assert property (p_xfer_delay)
        else $error("transfer strobe not two cycles after last shift");
    a_chain_order: assert property (p_chain_order)
        else $error("chain output out of order");
    a_chain_quiet: assert property (p_chain_quiet)
        else $error("chain output moved without a shift");

    c_rise: cover property ($rose(sclk));
    c_xfer: cover property ($fell(xfer_n));
    c_chain: cover property (rise && cnt_q == 9'h100);
endmodule

/* verification/serial_crosspoint_switch_loader_tb_top.sv */
// Self-checking bench: controller and device end to end, plus a device on a bench-driven link.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module serial_crosspoint_switch_loader_tb_top;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         load_req = 1'b0;
    logic [255:0] ld = '0;
    logic [255:0] pa;
    logic [255:0] pb;
    logic         busy, done, ret;
    logic [15:0][15:0] xpt1, xpt2;
    logic         upd1, lost1, slow1, fast1;
    logic         upd2, lost2, slow2, fast2;
    int           err_total = 0;
    int           checks = 0;
    int           cyc = 0;

    xpt_link_if link_a ();
    xpt_link_if link_b ();

    xpt_ctrl u_xpt_ctrl (.clk(clk), .rstn(rstn), .load_req(load_req), .load_data(ld),
        .busy_q(busy), .done_q(done), .chain_ret_q(ret), .link(link_a));
    xpt_device #(.RETAIN_CYC(2000)) u_xpt_device (.clk(clk), .rstn(rstn), .link(link_a),
        .xpt_on_q(xpt1), .update_q(upd1), .data_lost_q(lost1), .rate_slow_q(slow1),
        .rate_fast_q(fast1));
    // A second device whose link the bench drives, so faults can be made on purpose.
    xpt_device #(.RETAIN_CYC(2000)) u_xpt_device_2 (.clk(clk), .rstn(rstn), .link(link_b),
        .xpt_on_q(xpt2), .update_q(upd2), .data_lost_q(lost2), .rate_slow_q(slow2),
        .rate_fast_q(fast2));
    xpt_link_chk u_xpt_link_chk (.clk(clk), .rstn(rstn), .sclk(link_a.sclk),
        .serial_data_in(link_a.serial_data_in), .xfer_n(link_a.xfer_n),
        .chain_data_out(link_a.chain_data_out));

    // Clock at 20 MHz.
    always #25 clk = ~clk;

    // Cuts a hang short; the ceiling is about two and a half times the expected run.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    // Irregular pattern, so a swapped row, column or bit order shows.
    function automatic logic [255:0] mkpat(input int s);
        for (int k = 0; k < 256; k++) mkpat[k] = ((k * s + k / 7) % 3) == 0;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic t_reset();
        `CHK({busy, done, ret, link_a.sclk, link_a.xfer_n}, 5'b00001) // RESET
        `CHK({upd1, lost1, slow1, fast1}, 4'h0) // RESET
        `CHK(xpt1, 256'h0) // RESET
        $display("test reset done");
    endtask

    // Load through the controller; a second request mid-load must be ignored.
    task automatic t_load(input logic [255:0] pat, input logic [255:0] prev);
        int   n;
        int   load_cyc;
        logic seen;
        ld = pat;
        // Four clocks per bit at the fastest legal rate, then gap and strobe.
        load_cyc = 2 * xpt_pkg::SCLK_HALF_MIN_CYC * xpt_pkg::SHIFT_BITS
                   + xpt_pkg::XFER_DLY_CYC + xpt_pkg::XFER_PW_CYC;
        @(posedge clk) #2 load_req = 1'b1;
        @(posedge clk) #2 load_req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(posedge clk) #2 n++;
            load_req = (n == 500);
            if (n == 600)
            begin
                `CHK(busy, 1'b1)
                `CHK(xpt1, prev)
            end
        end
        `CHK(n, load_cyc)
        `CHK(busy, 1'b0)
        seen = 1'b0;
        repeat (8) @(posedge clk) #2 if (upd1 === 1'b1) seen = 1'b1;
        `CHK(seen, 1'b1)
        `CHK(xpt1, pat)
        `CHK(ret, pat[255])
        $display("test load done");
    endtask

    task automatic t_hold();
        repeat (2500) @(posedge clk);
        #2;
        `CHK(xpt1, pb)
        `CHK({lost1, slow1, fast1}, 3'b000)
        $display("test hold done");
    endtask

    // One bit on the bench link; checks what the next device in a chain would see.
    task automatic t_bit(input logic b, input int h, input bit chk, input logic e);
        link_b.serial_data_in = b;
        repeat (h) @(posedge clk);
        #2;
        if (chk) `CHK(link_b.chain_data_out, e)
        link_b.sclk = 1'b1;
        repeat (h) @(posedge clk);
        #2;
        link_b.sclk = 1'b0;
    endtask

    task automatic shift_b(input logic [255:0] v, input bit chk, input logic [255:0] old);
        for (int k = 255; k >= 0; k--) t_bit(v[k], 2, chk, old[k]);
    endtask

    task automatic strobe_b(output logic seen);
        repeat (2) @(posedge clk);
        #2 link_b.xfer_n = 1'b0;
        repeat (3) @(posedge clk);
        #2 link_b.xfer_n = 1'b1;
        seen = 1'b0;
        repeat (8) @(posedge clk) #2 if (upd2 === 1'b1) seen = 1'b1;
    endtask

    // A strobe before any shifting finds stale data and is refused.
    task automatic t_refuse();
        logic seen;
        strobe_b(seen);
        `CHK(seen, 1'b0)
        `CHK(lost2, 1'b1)
        `CHK(xpt2, 256'h0)
        $display("test refuse done");
    endtask

    task automatic t_rate();
        t_bit(1'b1, 1, 0, 1'b0);
        t_bit(1'b0, 1, 0, 1'b0);
        repeat (4) @(posedge clk);
        #2;
        `CHK(fast2, 1'b1)
        repeat (1200) @(posedge clk);
        #2;
        `CHK(slow2, 1'b1)
        $display("test rate done");
    endtask

    // Two patterns shifted back to back, then one strobe; the first must leave by the chain output in order.
    task automatic t_direct();
        logic seen;
        shift_b(pa, 0, 256'h0);
        shift_b(pb, 1, pa);
        `CHK(xpt2, 256'h0)
        strobe_b(seen);
        `CHK(seen, 1'b1)
        `CHK(xpt2, pb)
        `CHK({lost2, slow2, fast2}, 3'b000)
        $display("test direct done");
    endtask

    // Main sequence.
    initial
    begin
        link_b.sclk = 1'b0;
        link_b.serial_data_in = 1'b0;
        link_b.xfer_n = 1'b1;
        pa = mkpat(5);
        pb = mkpat(11);
        repeat (12) @(posedge clk);
        #2 rstn = 1'b1;
        t_reset();
        t_load(pa, 256'h0);
        t_load(pb, pa);
        t_hold();
        t_refuse();
        t_rate();
        t_direct();
        end_sim();
    end
endmodule
